// [hdl/adc_control.sv]
// Function
// - control bit 7 set lets end of conversion raise the interrupt; clear masks it
// - bit 6 flags a finished conversion; software cannot write it
// - writing the start bit with one clears the finished flag
// - the result counts as valid only while the finished flag reads one
// - the finished flag doubles as the interrupt pending bit
// - writing one to bit 5 starts a conversion only when the same write also sets power bit 4
// - a start during a conversion drops it and begins a new one
// - the start bit always reads back as zero
// - power bit 4 at one lets the converter run conversions
// - power bit at zero puts the converter into idle power down
// - the read-only result register holds the full 8-bit outcome
// - the supply span is split into 256 equal code steps
// - the converter keeps running while the core waits
// - the end-of-conversion interrupt can wake the waiting core
// - the approximation steps run on the clock divided by twelve
// - reset stops conversion, control reads 40h, interrupt masked
// - the interrupt request goes to core vector four
// - one conversion takes about 70 us
`timescale 1ns/1ps
`default_nettype none

module adc_control #(
  parameter int unsigned CONV_CYCLES = adc_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [adc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [adc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // analog front end
  input wire logic cmp_pin,
  output logic [adc_pkg::RESULT_BITS-1:0] dac_code,
  output logic conv_powered,
  // core side
  input wire logic core_wait,
  output logic conv_irq,
  output logic core_wake
);
  import adc_pkg::*;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned RAW_STEP = CONV_CYCLES / (OSC_DIV * RESULT_BITS);
  localparam int unsigned STEP_TICKS = (RAW_STEP < 1) ? 1 : RAW_STEP;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic rd_ctrl;
    logic irq_en;
    logic eoc;
    logic power;
    logic start;
  } ctl_s;

  localparam ctl_s CTL_RESET = '{
    irq_en: CTRL_RESET[IRQ_EN_BIT],
    eoc: CTRL_RESET[EOC_BIT],
    power: CTRL_RESET[POWER_BIT],
    bresp: RESP_OKAY,
    rresp: RESP_OKAY,
    default: '0
  };

  ctl_s s;
  ctl_s next_s;
  logic wr_go;
  logic wr_ctrl;
  logic start_wr;
  logic [7:0] ctrl_view;

  sar_if sar ();

  // ----------------------------------------
  // converter core
  // ----------------------------------------
  adc_sar_seq #(
    .STEP_TICKS(STEP_TICKS)
  ) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .sar(sar.core),
    .cmp_pin(cmp_pin),
    .dac_code(dac_code)
  );

  assign sar.start = s.start;
  assign sar.powered = s.power;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  assign wr_go = s.aw_got && s.w_got && !s.bvalid;
  assign wr_ctrl = wr_go && (s.awaddr[ADDR_W-1:2] == CTRL_IDX);
  assign start_wr = wr_ctrl && s.wstrb[0] && s.wdata[START_BIT];

  // ----------------------------------------
  // control read view
  // ----------------------------------------
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[IRQ_EN_BIT] = s.irq_en;
    ctrl_view[EOC_BIT] = s.eoc;
    ctrl_view[POWER_BIT] = s.power;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;

    // address and data may come in either order
    if (awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.awaddr[ADDR_W-1:2] == CTRL_IDX) begin
        // finished flag and low bits are not writable
        if (s.wstrb[0]) begin
          next_s.irq_en = s.wdata[IRQ_EN_BIT];
          next_s.power = s.wdata[POWER_BIT];
          if (s.wdata[START_BIT]) begin
            next_s.eoc = 1'b0;
            // no power, no conversion
            next_s.start = s.wdata[POWER_BIT];
          end
        end
      end else if (s.awaddr[ADDR_W-1:2] == RESULT_IDX) begin
        next_s.bresp = RESP_OKAY;
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end

    // a finish in the same cycle as a clearing write wins
    if (sar.done) begin
      next_s.eoc = 1'b1;
    end

    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      next_s.rd_ctrl = 1'b0;
      if (araddr[ADDR_W-1:2] == CTRL_IDX) begin
        next_s.rdata[7:0] = ctrl_view;
        next_s.rd_ctrl = 1'b1;
      end else if (araddr[ADDR_W-1:2] == RESULT_IDX) begin
        // held from the last finish until the next one
        next_s.rdata[7:0] = sar.result;
      end else begin
        next_s.rresp = RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready = !s.aw_got;
  assign wready = !s.w_got;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign conv_powered = s.power;

  // level request for the core vector line; the flag is the pending bit
  assign conv_irq = s.irq_en && s.eoc;
  // converter never looks at core_wait, so it runs through wait mode
  assign core_wake = conv_irq && core_wait;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_IRQ_MASK: assert property (
    !s.irq_en |-> !conv_irq)
    else $error("interrupt raised while masked");

  AST_IRQ_RAISE: assert property (
    sar.done && s.irq_en && !wr_ctrl |=> conv_irq)
    else $error("interrupt missing after finish");

  AST_PENDING: assert property (
    conv_irq |-> s.eoc && $past(sar.done || s.eoc))
    else $error("interrupt without pending flag");

  AST_EOC_SET: assert property (
    sar.done |=> s.eoc)
    else $error("finished flag not set");

  AST_EOC_HOLD: assert property (
    !start_wr && s.eoc |=> s.eoc)
    else $error("finished flag lost without start");

  AST_EOC_CLR: assert property (
    start_wr && !sar.done |=> !s.eoc)
    else $error("start write did not clear flag");

  AST_START: assert property (
    start_wr && s.wdata[POWER_BIT] |=> s.start ##1 sar.busy)
    else $error("start did not begin a conversion");

  AST_RESTART: assert property (
    s.start && sar.busy |=> sar.busy && !sar.done)
    else $error("restart did not abandon conversion");

  AST_STA_READ: assert property (
    s.rvalid && s.rd_ctrl |-> s.rdata[START_BIT] == 1'b0)
    else $error("start bit read as one");

  AST_NEED_POWER: assert property (
    s.start |-> s.power)
    else $error("start issued while powered down");

  AST_POWER_DOWN: assert property (
    !s.power |=> !sar.busy)
    else $error("converter busy while powered down");

  AST_RESULT: assert property (
    $changed(sar.result) |-> sar.done)
    else $error("result changed outside a finish");

  AST_WAIT_RUN: assert property (
    sar.busy && core_wait && s.power && !s.start |=> sar.busy || sar.done)
    else $error("conversion stopped in wait mode");

  AST_WAKE: assert property (
    sar.done && s.irq_en && core_wait && !wr_ctrl ##1 core_wait
    |-> core_wake)
    else $error("core not woken at finish");

  AST_RESET: assert property (
    disable iff (1'b0)
    !aresetn |=> s.eoc && !s.irq_en && !s.power && !sar.busy && !conv_irq)
    else $error("reset state wrong");

  AST_LOW_ZERO: assert property (
    s.rvalid && s.rd_ctrl |-> s.rdata[3:0] == 4'h0)
    else $error("unused control bits read nonzero");

  COV_DONE: cover property (sar.done);
  COV_RESTART: cover property (s.start && sar.busy);
  COV_IRQ: cover property ($rose(conv_irq));
  COV_WAKE: cover property (core_wake);

endmodule // adc_control

`default_nettype wire

// [hdl/adc_pkg.sv]
`default_nettype none

package adc_pkg;

  // ----------------------------------------
  // register map (printed offsets are indices)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] RESULT_IDX = 10'h0D0;
  localparam logic [9:0] CTRL_IDX = 10'h0D1;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int unsigned IRQ_EN_BIT = 7;
  localparam int unsigned EOC_BIT = 6;
  localparam int unsigned START_BIT = 5;
  localparam int unsigned POWER_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ----------------------------------------
  // converter and timing
  // ----------------------------------------
  localparam int unsigned RESULT_BITS = 8;
  localparam int unsigned OSC_DIV = 12;
  localparam int unsigned IRQ_VECTOR = 4;
  localparam int unsigned CONV_TIME_NS = 70000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // bus answers and sequencer states
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    SAR_IDLE,
    SAR_RUN
  } sar_state_e;

endpackage

`default_nettype wire

// [hdl/adc_sar_seq.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_sar_seq #(
  parameter int unsigned STEP_TICKS = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  sar_if.core sar,
  // analog front end
  input wire logic cmp_pin,
  output logic [adc_pkg::RESULT_BITS-1:0] dac_code
);
  import adc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sar_state_e state;
    logic [3:0] div;
    logic [15:0] tick;
    logic [2:0] idx;
    logic [7:0] trial;
    logic [7:0] result;
    logic done;
    logic cmp_meta;
    logic cmp_sync;
    logic [15:0] run_cnt;
  } seq_s;

  localparam seq_s SEQ_RESET = '{state: SAR_IDLE, result: RESULT_RESET,
                                 default: '0};
  localparam logic [15:0] LAST_TICK = 16'(STEP_TICKS - 1);
  localparam logic [15:0] TOTAL = 16'(OSC_DIV * RESULT_BITS * STEP_TICKS);

  seq_s s;
  seq_s next_s;

  // ----------------------------------------
  // successive approximation
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.cmp_meta = cmp_pin;
    next_s.cmp_sync = s.cmp_meta;
    if (s.state == SAR_RUN) begin
      next_s.run_cnt = s.run_cnt + 16'h0001;
    end
    if (!sar.powered) begin
      next_s.state = SAR_IDLE;
    end else if (sar.start) begin
      // a start always wins: the running conversion is dropped
      next_s.state = SAR_RUN;
      next_s.div = 4'h0;
      next_s.tick = 16'h0000;
      next_s.idx = 3'(RESULT_BITS - 1);
      next_s.trial = 8'h80;
      next_s.run_cnt = 16'h0000;
    end else if (s.state == SAR_RUN) begin
      if (s.div == 4'(OSC_DIV - 1)) begin
        next_s.div = 4'h0;
        if (s.tick == LAST_TICK) begin
          next_s.tick = 16'h0000;
          // keep the trial bit only while the input is at or above it
          next_s.trial[s.idx] = s.cmp_sync;
          if (s.idx == 3'h0) begin
            next_s.state = SAR_IDLE;
            next_s.result = next_s.trial;
            next_s.done = 1'b1;
          end else begin
            next_s.idx = s.idx - 3'h1;
            next_s.trial[s.idx - 3'h1] = 1'b1;
          end
        end else begin
          next_s.tick = s.tick + 16'h0001;
        end
      end else begin
        next_s.div = s.div + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= SEQ_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign sar.busy = (s.state == SAR_RUN);
  assign sar.done = s.done;
  assign sar.result = s.result;
  assign dac_code = s.trial;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_CONV_LEN: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.done |-> s.run_cnt == TOTAL)
    else $error("conversion length wrong");

  AST_MSB_FIRST: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sar.start && sar.powered |=> s.trial == 8'h80 && s.idx == 3'h7)
    else $error("conversion does not begin at the top bit");

endmodule // adc_sar_seq

`default_nettype wire

// [hdl/sar_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface sar_if;
  logic start;
  logic powered;
  logic busy;
  logic done;
  logic [7:0] result;

  modport ctl (
    output start,
    output powered,
    input busy,
    input done,
    input result
  );

  modport core (
    input start,
    input powered,
    output busy,
    output done,
    output result
  );
endinterface

`default_nettype wire

// [tb/adc_control_and_result_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("Error %s expected %0h seen %0h", nm, ex, got); \
  err_count++; end end

module adc_control_and_result_tb;
  import adc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int CONV = 96;
  localparam logic [11:0] A_RES = {RESULT_IDX, 2'h0};
  localparam logic [11:0] A_CTL = {CTRL_IDX, 2'h0};
  localparam logic [11:0] A_BAD = 12'h000;
  typedef struct packed {
    logic [7:0] lv, wv, ec;
    logic irq, wt;
  } row_s;
  row_s rows [5] = '{'{8'h00, 8'h3F, 8'h50, 1'b0, 1'b0},
    '{8'hFF, 8'hBF, 8'hD0, 1'b1, 1'b1}, '{8'h80, 8'hB0, 8'hD0, 1'b1, 1'b0},
    '{8'h5A, 8'h30, 8'h50, 1'b0, 1'b1}, '{8'hA5, 8'h70, 8'h50, 1'b0, 1'b0}};
  logic aclk = 1'b0, aresetn = 1'b0, core_wait = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] level = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, cmp_pin;
  logic conv_powered, conv_irq, core_wake;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic [7:0] dac_code;
  int err_count = 0, tests_run = 0;

  always #5 aclk = ~aclk;

  adc_control #(.CONV_CYCLES(CONV)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cmp_pin(cmp_pin), .dac_code(dac_code),
    .conv_powered(conv_powered), .core_wait(core_wait),
    .conv_irq(conv_irq), .core_wake(core_wake));

  adc_source src (.aclk(aclk), .powered(conv_powered), .dac_code(dac_code),
    .cmp_pin(cmp_pin), .level(level));

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    $display("Error wait expected done seen timeout");
    err_count++;
    final_report();
  endtask

  // handshakes judged at the falling edge, acted on at the next rise
  task automatic bus_wr(input logic [11:0] a, input logic [7:0] v);
    bit aw_hs, w_hs, b_hs;
    awaddr <= a;
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid === 1'b1;
      resp = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        // one edge with bready low, so a next call never re-raises it here
        @(posedge aclk);
        return;
      end
    end
    timeout();
  endtask

  task automatic bus_rd(input logic [11:0] a);
    bit ar_hs, r_hs;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid === 1'b1;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    timeout();
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] ex,
                        input string nm);
    bus_rd(a);
    `CHK(nm, {24'h000000, ex}, d)
  endtask

  task automatic pins(input logic irq, input logic wake, input logic pw);
    @(negedge aclk);
    `CHK("conv_irq", irq, conv_irq)
    `CHK("core_wake", wake, core_wake)
    `CHK("conv_powered", pw, conv_powered)
    @(posedge aclk);
  endtask

  // polling is bounded; conversion needs only CONV cycles
  task automatic wait_eoc();
    for (int i = 0; i < 60; i++) begin
      bus_rd(A_CTL);
      if (d[EOC_BIT] === 1'b1) return;
    end
    timeout();
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(A_CTL, CTRL_RESET, "ctrl reset");
    rd_chk(A_RES, RESULT_RESET, "result reset");
    pins(1'b0, 1'b0, 1'b0);
    foreach (rows[i]) begin
      level <= rows[i].lv;
      bus_wr(A_CTL, rows[i].wv);
      core_wait <= rows[i].wt;
      rd_chk(A_CTL, rows[i].ec & 8'hBF, "eoc cleared");
      repeat (CONV / 2) @(posedge aclk);
      rd_chk(A_CTL, rows[i].ec & 8'hBF, "early eoc");
      wait_eoc();
      rd_chk(A_RES, rows[i].lv, "result");
      rd_chk(A_CTL, rows[i].ec, "ctrl");
      pins(rows[i].irq, rows[i].irq & rows[i].wt, 1'b1);
      core_wait <= 1'b0;
    end
    bus_wr(A_CTL, 8'h10);
    rd_chk(A_CTL, 8'h50, "eoc kept");
    bus_wr(A_CTL, 8'h90);
    pins(1'b1, 1'b0, 1'b1);
    bus_wr(A_CTL, 8'h10);
    pins(1'b0, 1'b0, 1'b1);
    bus_rd(A_BAD);
    `CHK("bad read resp", RESP_SLVERR, resp)
    bus_wr(A_BAD, 8'hFF);
    `CHK("bad write resp", RESP_SLVERR, resp)
    bus_wr(A_RES, 8'hFF);
    `CHK("result write resp", RESP_OKAY, resp)
    rd_chk(A_RES, 8'hA5, "result ro");
    // restart: first conversion would have ended inside the gap
    level <= 8'h33;
    bus_wr(A_CTL, 8'h30);
    repeat (40) @(posedge aclk);
    level <= 8'hC6;
    bus_wr(A_CTL, 8'h30);
    repeat (60) @(posedge aclk);
    rd_chk(A_CTL, 8'h10, "restart busy");
    wait_eoc();
    rd_chk(A_RES, 8'hC6, "restart result");
    bus_wr(A_CTL, 8'h30);
    repeat (30) @(posedge aclk);
    bus_wr(A_CTL, 8'h00);
    pins(1'b0, 1'b0, 1'b0);
    repeat (CONV + 20) @(posedge aclk);
    rd_chk(A_CTL, 8'h00, "aborted");
    bus_wr(A_CTL, 8'h20);
    repeat (CONV + 20) @(posedge aclk);
    rd_chk(A_CTL, 8'h00, "unpowered");
    bus_wr(A_CTL, 8'hB0);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(A_CTL, CTRL_RESET, "ctrl rereset");
    pins(1'b0, 1'b0, 1'b0);
    `CHK("dac_code", 8'h00, dac_code)
    repeat (CONV + 20) @(posedge aclk);
    rd_chk(A_RES, RESULT_RESET, "halted");
    final_report();
  end
endmodule // adc_control_and_result_tb

`default_nettype wire

// [tb/adc_source.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_source (
  // clock
  input wire logic aclk,
  // converter side
  input wire logic powered,
  input wire logic [7:0] dac_code,
  output logic cmp_pin,
  // bench side
  input wire logic [7:0] level
);
  // ----------------------------------------
  // comparator
  // ----------------------------------------
  logic noise = 1'b0;

  always @(posedge aclk) begin
    noise <= ~noise;
  end

  // unpowered comparator gives no stable answer, so it chatters
  assign cmp_pin = powered ? (level >= dac_code) : noise;
endmodule // adc_source

`default_nettype wire
